// ===== hdl/cct_core_ctrl.sv
// core control register, trap flags and table access to program memory
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_core_ctrl (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [7:0]  s_awaddr,
  // axi4-lite write data
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  // axi4-lite write response
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  // axi4-lite read address
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [7:0]  s_araddr,
  // axi4-lite read data
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  // cpu core events, same clock
  input  wire logic        loop_start,
  input  wire logic        loop_end,
  input  wire logic        stack_trap,
  input  wire logic        osc_trap,
  input  wire logic [3:0]  cpu_lvl_set,
  input  wire logic        cpu_lvl_load,
  // table instruction request, same clock
  input  wire logic        tbl_valid,
  input  wire logic        tbl_high,
  input  wire logic        tbl_write,
  input  wire logic        tbl_byte,
  input  wire logic [15:0] tbl_addr,
  input  wire logic [15:0] tbl_wdata,
  output logic             tbl_done,
  output logic [15:0]      tbl_rdata,
  output logic             tbl_busy,
  // program memory port
  output logic             pm_req,
  output logic             pm_we,
  output logic [1:0]       pm_wlane,
  output logic [23:0]      pm_addr,
  output logic [23:0]      pm_wdata,
  input  wire logic        pm_ack,
  input  wire logic [23:0] pm_rdata,
  // core control outputs
  output logic             var_latency,
  output logic [1:0]       multiply_sign_mode,
  output logic             acc_a_sat_enable,
  output logic             acc_b_sat_enable,
  output logic             store_sat_enable,
  output logic             sat_width_select,
  output logic             early_loop_exit,
  output logic [2:0]       loop_nest_depth,
  output logic [3:0]       cpu_priority_level,
  output logic             config_space,
  output logic             irq
);

  cct_pkg::cct_state_type s_reg;
  cct_pkg::cct_state_type s_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    merge16 = old;
    if (be[0]) merge16[7:0] = d[7:0];
    if (be[1]) merge16[15:8] = d[15:8];
  endfunction

  function automatic logic [15:0] tbl_pick(input logic [23:0] w, input logic high,
                                           input logic bytem, input logic bsel);
    tbl_pick = 16'h0000;
    // table read selection
    if (!high && !bytem)
      tbl_pick = w[15:0];
    else if (!high)
      tbl_pick = {8'h00, (bsel ? w[15:8] : w[7:0])};
    else if (!bytem || !bsel)
      tbl_pick = {8'h00, w[23:16]};
  endfunction

  logic        wr_fire;
  logic        rd_fire;
  logic [15:0] cc_view;
  logic [15:0] ic1_view;
  logic [3:0]  lvl_now;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.loop_exit = 1'b0;
    s_next.tbl_done = 1'b0;
    wr_fire = s_reg.awv && s_reg.wv && !s_reg.bvalid;
    rd_fire = s_arvalid && s_reg.arready;
    lvl_now = {s_reg.core_control[`CCT_CC_PRIO_MSB_BIT], s_reg.status_lvl};
    if (loop_start && !loop_end && s_reg.loop_depth != 3'h7)
      s_next.loop_depth = s_reg.loop_depth + 3'h1;
    else if (loop_end && !loop_start && s_reg.loop_depth != 3'h0)
      s_next.loop_depth = s_reg.loop_depth - 3'h1;
    // write channel capture
    if (s_awvalid && !s_reg.awv) begin
      s_next.awv = 1'b1;
      s_next.awaddr = s_awaddr;
    end
    if (s_wvalid && !s_reg.wv) begin
      s_next.wv = 1'b1;
      s_next.wdata = s_wdata;
      s_next.wstrb = s_wstrb;
    end
    if (s_reg.bvalid && s_bready)
      s_next.bvalid = 1'b0;
    if (wr_fire) begin
      s_next.awv = 1'b0;
      s_next.wv = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = 2'h0;
      case (s_reg.awaddr)
        `CCT_OFS_CORE_CONTROL: begin
          s_next.core_control = merge16(s_reg.core_control, s_reg.wdata, s_reg.wstrb)
                                & 16'hB0F3 | (s_reg.core_control & 16'h000C);
          if (s_reg.wstrb[0] && !s_reg.wdata[`CCT_CC_PRIO_MSB_BIT])
            s_next.core_control[`CCT_CC_PRIO_MSB_BIT] = 1'b0;
          if (s_reg.wstrb[1] && s_reg.wdata[`CCT_CC_EXIT_BIT])
            s_next.loop_exit = 1'b1;
        end
        `CCT_OFS_TABLE_PAGE:
          if (s_reg.wstrb[0]) s_next.table_page = s_reg.wdata[7:0];
        `CCT_OFS_STATUS_WORD:
          if (s_reg.wstrb[0]) s_next.status_lvl = s_reg.wdata[7:5];
        `CCT_OFS_IRQ_STATUS:
          if (s_reg.wstrb[0]) s_next.irq_status = s_reg.irq_status & ~s_reg.wdata[1:0];
        `CCT_OFS_IRQ_MASK:
          if (s_reg.wstrb[0]) s_next.irq_mask = s_reg.wdata[1:0];
        `CCT_OFS_INT_CTRL_ONE: begin
          // trap flags clear by writing zero
          if (s_reg.wstrb[0] && !s_reg.wdata[`CCT_IC1_STK_BIT]) s_next.stk_flag = 1'b0;
          if (s_reg.wstrb[0] && !s_reg.wdata[`CCT_IC1_OSC_BIT]) s_next.osc_flag = 1'b0;
        end
        default: s_next.bresp = 2'h2;
      endcase
    end
    // cpu priority level load, hardware wins over software
    // level split
    if (cpu_lvl_load) begin
      s_next.core_control[`CCT_CC_PRIO_MSB_BIT] = cpu_lvl_set[3];
      s_next.status_lvl = cpu_lvl_set[2:0];
    end
    if (stack_trap) begin
      s_next.stk_flag = 1'b1;
      s_next.irq_status[`CCT_IRQ_STK_BIT] = 1'b1;
    end
    if (osc_trap) begin
      s_next.osc_flag = 1'b1;
      s_next.irq_status[`CCT_IRQ_OSC_BIT] = 1'b1;
    end
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    // read channel
    s_next.arready = !s_reg.rvalid && !rd_fire;
    if (s_reg.rvalid && s_rready)
      s_next.rvalid = 1'b0;
    if (rd_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = 2'h0;
      s_next.rdata = 32'h0000_0000;
      case (s_araddr)
        `CCT_OFS_CORE_CONTROL: s_next.rdata[15:0] = cc_view;
        `CCT_OFS_INT_CTRL_ONE: s_next.rdata[15:0] = ic1_view;
        `CCT_OFS_TABLE_PAGE:   s_next.rdata[7:0] = s_reg.table_page;
        `CCT_OFS_STATUS_WORD:  s_next.rdata[7:5] = s_reg.status_lvl;
        `CCT_OFS_IRQ_STATUS:   s_next.rdata[1:0] = s_reg.irq_status;
        `CCT_OFS_IRQ_MASK:     s_next.rdata[1:0] = s_reg.irq_mask;
        default:               s_next.rresp = 2'h2;
      endcase
    end
    // table access engine
    case (s_reg.tst)
      cct_pkg::CCT_ST_IDLE: begin
        if (tbl_valid) begin
          s_next.tst = cct_pkg::CCT_ST_WAIT;
          s_next.tbl_high = tbl_high;
          s_next.tbl_byte = tbl_byte;
          s_next.tbl_bsel = tbl_addr[0];
          s_next.tbl_write = tbl_write;
          s_next.pm_req = 1'b1;
          s_next.pm_we = tbl_write;
          // page plus word address, step of two per word
          s_next.pm_addr = {s_reg.table_page, tbl_addr[15:1], 1'b0};
          // lane choice: low word, upper byte, or no lane for an odd high byte
          if (tbl_high) begin
            s_next.pm_wlane = (tbl_byte && tbl_addr[0]) ? 2'h0 : 2'h2;
            s_next.pm_wdata = {tbl_wdata[7:0], 16'h0000};
          end else begin
            s_next.pm_wlane = 2'h1;
            s_next.pm_wdata = {8'h00, tbl_wdata};
            if (tbl_byte)
              s_next.pm_wdata[15:0] = tbl_addr[0] ? {tbl_wdata[7:0], 8'h00}
                                                  : {8'h00, tbl_wdata[7:0]};
          end
        end
      end
      cct_pkg::CCT_ST_WAIT: begin
        if (pm_ack) begin
          s_next.pm_req = 1'b0;
          s_next.pm_we = 1'b0;
          s_next.tst = cct_pkg::CCT_ST_RESP;
          s_next.tbl_rdata = s_reg.tbl_write ? 16'h0000
                             : tbl_pick(pm_rdata, s_reg.tbl_high, s_reg.tbl_byte,
                                        s_reg.tbl_bsel);
        end
      end
      cct_pkg::CCT_ST_RESP: begin
        s_next.tbl_done = 1'b1;
        s_next.tst = cct_pkg::CCT_ST_IDLE;
      end
      default: s_next.tst = cct_pkg::CCT_ST_IDLE;
    endcase
  end

  // depth shown live, exit bit reads zero
  assign cc_view = {s_reg.core_control[15:12], 1'b0, s_reg.loop_depth,
                    s_reg.core_control[7:0]};
  assign ic1_view = {13'h0000, s_reg.stk_flag, s_reg.osc_flag, 1'b0};

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.core_control <= `CCT_CC_RESET;
      s_reg.tst <= cct_pkg::CCT_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_awready = !s_reg.awv;
  assign s_wready = !s_reg.wv;
  assign s_bvalid = s_reg.bvalid;
  assign s_bresp = s_reg.bresp;
  assign s_arready = s_reg.arready;
  assign s_rvalid = s_reg.rvalid;
  assign s_rdata = s_reg.rdata;
  assign s_rresp = s_reg.rresp;
  assign tbl_done = s_reg.tbl_done;
  assign tbl_rdata = s_reg.tbl_rdata;
  assign tbl_busy = s_reg.tst != cct_pkg::CCT_ST_IDLE;
  assign pm_req = s_reg.pm_req;
  assign pm_we = s_reg.pm_we;
  assign pm_wlane = s_reg.pm_wlane;
  assign pm_addr = s_reg.pm_addr;
  assign pm_wdata = s_reg.pm_wdata;
  assign var_latency = s_reg.core_control[`CCT_CC_VAR_BIT];
  assign multiply_sign_mode = s_reg.core_control[`CCT_CC_SIGN_HI:`CCT_CC_SIGN_LO];
  assign acc_a_sat_enable = s_reg.core_control[`CCT_CC_SAT_A_BIT];
  assign acc_b_sat_enable = s_reg.core_control[`CCT_CC_SAT_B_BIT];
  assign store_sat_enable = s_reg.core_control[`CCT_CC_SAT_ST_BIT];
  assign sat_width_select = s_reg.core_control[`CCT_CC_SAT_W_BIT];
  assign early_loop_exit = s_reg.loop_exit;
  assign loop_nest_depth = s_reg.loop_depth;
  assign cpu_priority_level = lvl_now;
  assign config_space = s_reg.table_page[`CCT_PAGE_CFG_BIT];
  assign irq = s_reg.irq;

endmodule

// ===== hdl/cct_map.svh
// register offsets, field positions and reset values for the core control block
`ifndef CCT_MAP_SVH
`define CCT_MAP_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CCT_OFS_CORE_CONTROL   8'h00
`define CCT_OFS_INT_CTRL_ONE   8'h04
`define CCT_OFS_TABLE_PAGE     8'h08
`define CCT_OFS_IRQ_STATUS     8'h0C
`define CCT_OFS_IRQ_MASK       8'h10
`define CCT_OFS_STATUS_WORD    8'h14

// ----------------------------------------
// core_control fields
// ----------------------------------------
`define CCT_CC_VAR_BIT         15
`define CCT_CC_SIGN_HI         13
`define CCT_CC_SIGN_LO         12
`define CCT_CC_EXIT_BIT        11
`define CCT_CC_DEPTH_HI        10
`define CCT_CC_DEPTH_LO        8
`define CCT_CC_SAT_A_BIT       7
`define CCT_CC_SAT_B_BIT       6
`define CCT_CC_SAT_ST_BIT      5
`define CCT_CC_SAT_W_BIT       4
`define CCT_CC_PRIO_MSB_BIT    3
`define CCT_CC_RESET           16'h0020
`define CCT_SIGN_SIGNED        2'h0
`define CCT_SIGN_UNSIGNED      2'h1
`define CCT_SIGN_MIXED         2'h2

// ----------------------------------------
// interrupt_control_one fields, irq bits and the table_page config bit
// ----------------------------------------
`define CCT_IC1_STK_BIT        2
`define CCT_IC1_OSC_BIT        1
`define CCT_IRQ_STK_BIT        0
`define CCT_IRQ_OSC_BIT        1
`define CCT_PAGE_CFG_BIT       7

`endif

// ===== hdl/cct_pkg.sv
// types for the core control and table access block
package cct_pkg;
  typedef enum logic [2:0] {
    CCT_ST_IDLE = 3'h1,
    CCT_ST_WAIT = 3'h2,
    CCT_ST_RESP = 3'h4
  } cct_tbl_state_type;

  typedef struct packed {
    logic [15:0]       core_control;
    logic [2:0]        loop_depth;
    logic              stk_flag;
    logic              osc_flag;
    logic [7:0]        table_page;
    logic [2:0]        status_lvl;
    logic [1:0]        irq_status;
    logic [1:0]        irq_mask;
    logic              irq;
    logic              loop_exit;
    logic              awv;
    logic [7:0]        awaddr;
    logic              wv;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    cct_tbl_state_type tst;
    logic              tbl_high;
    logic              tbl_byte;
    logic              tbl_bsel;
    logic              tbl_write;
    logic [15:0]       tbl_wdata;
    logic              pm_req;
    logic              pm_we;
    logic [1:0]        pm_wlane;
    logic [23:0]       pm_wdata;
    logic [23:0]       pm_addr;
    logic              tbl_done;
    logic [15:0]       tbl_rdata;
  } cct_state_type;
endpackage

// ===== verif/cct_core_ctrl_asserts.sv
// concurrent checks on the core control and table access ports
`timescale 1ns/1ps
module cct_core_ctrl_asserts (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // table side
  input wire logic        tbl_valid,
  input wire logic        tbl_busy,
  input wire logic        tbl_high,
  input wire logic        tbl_byte,
  input wire logic [15:0] tbl_addr,
  input wire logic        tbl_done,
  input wire logic [15:0] tbl_rdata,
  input wire logic        pm_req,
  input wire logic        pm_ack,
  input wire logic [23:0] pm_addr,
  // core side
  input wire logic        config_space,
  input wire logic        store_sat_enable,
  input wire logic        early_loop_exit,
  input wire logic        loop_start,
  input wire logic        loop_end,
  input wire logic [2:0]  loop_nest_depth,
  input wire logic        cpu_lvl_load,
  input wire logic [3:0]  cpu_lvl_set,
  input wire logic [3:0]  cpu_priority_level
);
  // ----------------------------------------
  // mode of the access in flight
  // ----------------------------------------
  logic hi_q;
  logic by_q;
  logic bs_q;
  always_ff @(posedge aclk) begin
    if (tbl_valid && !tbl_busy) begin
      hi_q <= tbl_high;
      by_q <= tbl_byte;
      bs_q <= tbl_addr[0];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STORE_SAT_RST: assert property ($rose(aresetn) |-> store_sat_enable)
    else $error("store saturation enable low after reset");
  AST_TBL_REQ: assert property (tbl_valid && !tbl_busy |=> pm_req)
    else $error("table request not forwarded");
  AST_PM_HOLD: assert property (pm_req && !pm_ack |=> pm_req && $stable(pm_addr))
    else $error("memory request dropped or changed before ack");
  AST_PM_ADDR: assert property (pm_req |-> !pm_addr[0] && pm_addr[23] == config_space)
    else $error("memory address misformed");
  AST_DONE_LAT: assert property (pm_req && pm_ack |-> ##2 tbl_done)
    else $error("table done not two cycles after ack");
  AST_HIGH_WORD: assert property (tbl_done && hi_q && !by_q |-> tbl_rdata[15:8] == 8'h00)
    else $error("upper data byte not zero on high word read");
  AST_HIGH_BYTE: assert property (tbl_done && hi_q && by_q && bs_q |-> tbl_rdata == 16'h0000)
    else $error("phantom byte read not zero");
  AST_EXIT_PULSE: assert property (early_loop_exit |=> !early_loop_exit)
    else $error("loop exit longer than one cycle");
  AST_DEPTH_UP: assert property (loop_start && !loop_end && loop_nest_depth != 3'h7
    |=> loop_nest_depth == $past(loop_nest_depth) + 3'h1)
    else $error("loop depth did not count up");
  AST_PRIO_LOAD: assert property (cpu_lvl_load |=> cpu_priority_level == $past(cpu_lvl_set))
    else $error("priority level not loaded");
endmodule

// ===== verif/cct_core_ctrl_tb.sv
// self-checking bench for the core control and table access block
`timescale 1ns/1ps
`include "cct_map.svh"
module cct_core_ctrl_tb;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, loop_start, loop_end, stack_trap, osc_trap;
  logic cpu_lvl_load, tbl_valid, tbl_high, tbl_write, tbl_byte, tbl_done, tbl_busy;
  logic pm_req, pm_we, pm_ack, var_latency, acc_a_sat_enable, acc_b_sat_enable;
  logic store_sat_enable, sat_width_select, early_loop_exit, config_space, irq;
  logic [7:0]  s_awaddr, s_araddr, pg;
  logic [31:0] s_wdata, s_rdata, rd, v;
  logic [3:0]  s_wstrb, cpu_lvl_set, cpu_priority_level, p;
  logic [1:0]  s_bresp, s_rresp, pm_wlane, multiply_sign_mode, rsp;
  logic [15:0] tbl_addr, tbl_wdata, tbl_rdata, tr, wlo, whi, a;
  logic [23:0] pm_addr, pm_wdata, pm_rdata;
  logic [2:0]  loop_nest_depth;
  logic [6:0]  flds;
  int          err_total = 0;
  int          num_checks = 0;
  int          n_exit = 0;

  assign flds = {var_latency, multiply_sign_mode, acc_a_sat_enable, acc_b_sat_enable,
                 store_sat_enable, sat_width_select};
  cct_core_ctrl dut (.*);
  cct_pm_model  pmm (.*);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) if (early_loop_exit) n_exit <= n_exit + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------
  // bus and event drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awvalid <= 1'b1;
    s_awaddr <= ad;
    s_wvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_awvalid && s_awready) aw_ok = 1'b1;
      if (s_wvalid && s_wready) w_ok = 1'b1;
      if (aw_ok) s_awvalid <= 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (!s_bvalid);
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] ad);
    s_arvalid <= 1'b1;
    s_araddr <= ad;
    do @(posedge aclk); while (!s_arready);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    rdr(ad);
    chk(rd, exp);
  endtask
  // sel picks {loop_start, loop_end, stack_trap, osc_trap, cpu_lvl_load}
  task automatic pulse(input logic [4:0] sel, input int n);
    repeat (n) begin
      {loop_start, loop_end, stack_trap, osc_trap, cpu_lvl_load} <= sel;
      @(posedge aclk);
      {loop_start, loop_end, stack_trap, osc_trap, cpu_lvl_load} <= 5'h00;
      @(posedge aclk);
    end
  endtask
  task automatic top(input logic hi, input logic we, input logic by, input logic [15:0] ad,
                     input logic [15:0] d);
    tbl_valid <= 1'b1;
    tbl_high <= hi;
    tbl_write <= we;
    tbl_byte <= by;
    tbl_addr <= ad;
    tbl_wdata <= d;
    @(posedge aclk);
    tbl_valid <= 1'b0;
    do @(posedge aclk); while (!tbl_done);
    tr = tbl_rdata;
    @(posedge aclk);
  endtask

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, loop_start, loop_end} = '0;
    {stack_trap, osc_trap, cpu_lvl_load, tbl_valid, tbl_high, tbl_write, tbl_byte} = '0;
    {aresetn, s_awaddr, s_araddr, s_wdata, s_wstrb, cpu_lvl_set, tbl_addr, tbl_wdata} = '0;
    void'($urandom(24));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(`CCT_OFS_CORE_CONTROL, 32'h00000020);
    rchk(`CCT_OFS_INT_CTRL_ONE, 32'h00000000);
    rdr(8'h18);
    chk({30'h0, rsp}, 32'h00000002);
    wr(8'h18, 32'h00000000);
    chk({30'h0, rsp}, 32'h00000002);
    for (int m = 0; m < 3; m++) begin
      v = ($urandom() & 32'h000080F0) | (32'(m) << 12);
      wr(`CCT_OFS_CORE_CONTROL, v);
      chk({25'h0, flds}, {25'h0, v[15], v[13:12], v[7:4]});
      rchk(`CCT_OFS_CORE_CONTROL, v);
    end
    wr(`CCT_OFS_CORE_CONTROL, 32'h00000820);
    rchk(`CCT_OFS_CORE_CONTROL, 32'h00000020);
    wr(`CCT_OFS_CORE_CONTROL, 32'h00000020);
    chk(32'(n_exit), 32'h00000001);
    pulse(5'h10, 9);
    pulse(5'h08, 2);
    chk({29'h0, loop_nest_depth}, 32'h00000005);
    p = 4'($urandom_range(15, 8));
    cpu_lvl_set <= p;
    pulse(5'h01, 1);
    chk({28'h0, cpu_priority_level}, {28'h0, p});
    rchk(`CCT_OFS_CORE_CONTROL, 32'h00000528);
    wr(`CCT_OFS_CORE_CONTROL, 32'h00000020);
    wr(`CCT_OFS_CORE_CONTROL, 32'h00000028);
    rchk(`CCT_OFS_CORE_CONTROL, 32'h00000520);
    wr(`CCT_OFS_IRQ_MASK, 32'h00000002);
    pulse(5'h04, 1);
    pulse(5'h02, 1);
    rchk(`CCT_OFS_INT_CTRL_ONE, 32'h00000006);
    chk({31'h0, irq}, 32'h00000001);
    wr(`CCT_OFS_IRQ_STATUS, 32'h00000002);
    chk({31'h0, irq}, 32'h00000000);
    wr(`CCT_OFS_IRQ_MASK, 32'h00000001);
    chk({31'h0, irq}, 32'h00000001);
    wr(`CCT_OFS_IRQ_STATUS, 32'h00000001);
    wr(`CCT_OFS_INT_CTRL_ONE, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    rchk(`CCT_OFS_INT_CTRL_ONE, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      pg = {i[0], 7'($urandom())};
      a = 16'($urandom()) & 16'hFFFE;
      wlo = 16'($urandom());
      whi = 16'($urandom());
      wr(`CCT_OFS_TABLE_PAGE, {24'h0, pg});
      chk({31'h0, config_space}, {31'h0, pg[7]});
      top(1'b0, 1'b1, 1'b0, a, wlo);
      top(1'b1, 1'b1, 1'b0, a, whi);
      top(1'b0, 1'b0, 1'b0, a, 16'h0000);
      chk({16'h0, tr}, {16'h0, wlo});
      top(1'b1, 1'b0, 1'b0, a, 16'h0000);
      chk({16'h0, tr}, {24'h0, whi[7:0]});
      top(1'b1, 1'b0, 1'b1, a, 16'h0000);
      chk({16'h0, tr}, {24'h0, whi[7:0]});
      top(1'b0, 1'b0, 1'b1, a | 16'h0001, 16'h0000);
      chk({16'h0, tr}, {24'h0, wlo[15:8]});
      top(1'b0, 1'b0, 1'b1, a, 16'h0000);
      chk({16'h0, tr}, {24'h0, wlo[7:0]});
      top(1'b1, 1'b0, 1'b1, a | 16'h0001, 16'h0000);
      chk({16'h0, tr}, 32'h00000000);
    end
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
endmodule

bind cct_core_ctrl cct_core_ctrl_asserts chk_i (.*);

// ===== verif/cct_pm_model.sv
// program memory model answering table accesses after a random wait
`timescale 1ns/1ps
module cct_pm_model (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // program memory port
  input wire logic        pm_req,
  input wire logic        pm_we,
  input wire logic [1:0]  pm_wlane,
  input wire logic [23:0] pm_addr,
  input wire logic [23:0] pm_wdata,
  output logic            pm_ack,
  output logic [23:0]     pm_rdata
);
  logic [23:0] mem [logic [23:0]];
  logic [23:0] w;
  int          wait_cnt;
  initial begin
    pm_ack = 1'b0;
    pm_rdata = 24'h000000;
    wait_cnt = 0;
  end
  // read data toggles outside the read ack cycle
  always @(posedge aclk) begin
    pm_ack <= 1'b0;
    pm_rdata <= ~pm_rdata;
    if (!aresetn)
      wait_cnt <= 0;
    else if (pm_req && !pm_ack && wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
    else if (pm_req && !pm_ack) begin
      pm_ack <= 1'b1;
      wait_cnt <= $urandom_range(3, 0);
      w = mem.exists(pm_addr) ? mem[pm_addr] : ~pm_addr;
      // lower word and upper byte lanes
      if (pm_we && pm_wlane[0])
        w[15:0] = pm_wdata[15:0];
      if (pm_we && pm_wlane[1])
        w[23:16] = pm_wdata[23:16];
      mem[pm_addr] = w;
      if (!pm_we)
        pm_rdata <= w;
    end
  end
endmodule
